// *** logic/qdac_ctrl.sv ***
`timescale 1ns/1ps
module qdac_ctrl
   import qdac_pkg::*;
#(
   parameter int NCHAN = QDAC_NCHAN,
   parameter int WAKE_CYC = QDAC_WAKE_CYC,
   parameter bit HAS_STROBE_PIN = 1'b1
) (
   input wire logic clk_i, // Clock, 40 MHz.
   input wire logic rst_i, // Synchronous reset, active high.
   input wire qdac_frame_t frame_i, // Completed 24-bit write from the serial link.
   input wire logic load_strobe_n_i, // Load strobe pin, active low, asynchronous.
   output logic [NCHAN*QDAC_CODE_W-1:0] conv_code_o, // Converter register codes.
   output logic [NCHAN*2-1:0] pwr_state_o, // Power state per channel.
   output logic [NCHAN-1:0] out_valid_o, // Channel output settled.
   output logic [3:0] load_mask_o, // Current load mask.
   output logic ref_on_o // Internal reference enable.
);
   // The decode and the frame layout serve exactly four channels.
   if (NCHAN != QDAC_NCHAN) begin : g_bad_nchan
      $error("only four channels are supported");
   end

   // Address decode into a channel select mask, one bit set per addressed channel.
   function automatic logic [QDAC_NCHAN-1:0] addr_sel(input logic [2:0] a);
      case (a)
         QDAC_ADDR_A: addr_sel = 4'h1;
         QDAC_ADDR_B: addr_sel = 4'h2;
         QDAC_ADDR_C: addr_sel = 4'h4;
         QDAC_ADDR_D: addr_sel = 4'h8;
         QDAC_ADDR_ALL: addr_sel = 4'hF;
         default: addr_sel = 4'h0; // Unused addresses select nothing.
      endcase
   endfunction

   // The strobe pin is asynchronous, so it passes two flip-flops first.
   logic strobe_meta_q;
   logic strobe_sync_q;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         strobe_meta_q <= 1'b1;
         strobe_sync_q <= 1'b1;
      end else begin
         strobe_meta_q <= load_strobe_n_i;
         strobe_sync_q <= strobe_meta_q;
      end
   end

   // Without the pin the strobe is seen as idle high.
   logic strobe_low;
   assign strobe_low = HAS_STROBE_PIN ? !strobe_sync_q : 1'b0;

   // Frame fields.
   logic [2:0] cmd;
   logic [2:0] addr;
   logic [QDAC_CODE_W-1:0] data;
   logic [QDAC_NCHAN-1:0] sel;
   logic [QDAC_NCHAN-1:0] dsel;
   assign cmd = frame_i.word[QDAC_CMD_MSB:QDAC_CMD_LSB];
   assign addr = frame_i.word[QDAC_ADDR_MSB:QDAC_ADDR_LSB];
   assign data = frame_i.word[QDAC_DATA_MSB:QDAC_DATA_LSB];
   assign sel = addr_sel(addr);
   // Mask and power use data bits as channel select, address ignored.
   assign dsel = data[QDAC_SEL_MSB:QDAC_SEL_LSB];

   // Command strobes.
   logic do_write;
   logic do_upd;
   logic do_upd_all;
   logic do_pwr;
   logic do_mask;
   logic do_rst;
   logic do_full_rst;
   logic do_ref;
   always_comb begin
      do_write = 1'b0;
      do_upd = 1'b0;
      do_upd_all = 1'b0;
      do_pwr = 1'b0;
      do_mask = 1'b0;
      do_rst = 1'b0;
      do_ref = 1'b0;
      if (frame_i.valid) begin
         case (cmd)
            QDAC_CMD_WRITE: do_write = 1'b1;
            QDAC_CMD_UPDATE: do_upd = 1'b1;
            QDAC_CMD_WRITE_UPD_ALL: begin
               do_write = 1'b1;
               do_upd_all = 1'b1;
            end
            QDAC_CMD_WRITE_UPD: begin
               do_write = 1'b1;
               do_upd = 1'b1;
            end
            QDAC_CMD_POWER: do_pwr = 1'b1;
            QDAC_CMD_RESET: do_rst = 1'b1;
            QDAC_CMD_MASK: do_mask = 1'b1;
            default: do_ref = 1'b1;
         endcase
      end
   end
   assign do_full_rst = do_rst && data[QDAC_RST_BIT];

   // Load mask register.
   logic [3:0] mask_q;
   always_ff @(posedge clk_i) begin
      if (rst_i || do_full_rst) begin
         mask_q <= QDAC_MASK_RST;
      end else if (do_mask) begin
         mask_q <= dsel;
      end
   end

   // Reference enable, kept so the full reset has something to clear.
   always_ff @(posedge clk_i) begin
      if (rst_i || do_full_rst) begin
         ref_on_o <= 1'b0;
      end else if (do_ref) begin
         ref_on_o <= data[QDAC_RST_BIT];
      end
   end

   // Input registers, converter registers and changed flags.
   logic [QDAC_CODE_W-1:0] in_q [QDAC_NCHAN];
   logic [QDAC_CODE_W-1:0] conv_q [QDAC_NCHAN];
   logic [QDAC_NCHAN-1:0] dirty_q;
   logic [QDAC_NCHAN-1:0] wr_now;
   logic [QDAC_NCHAN-1:0] load;
   logic [QDAC_NCHAN-1:0] pwr_up;
   logic [QDAC_NCHAN-1:0] pwr_dn;
   qdac_pwr_t pwr_q [QDAC_NCHAN];
   qdac_pwr_t new_pwr;
   assign new_pwr = qdac_pwr_t'(data[QDAC_PSTATE_MSB:QDAC_PSTATE_LSB]);
   assign wr_now = do_write ? sel : '0;

   genvar g;
   generate
      for (g = 0; g < QDAC_NCHAN; g++) begin : g_chan
         // Channel updates: strobe low or mask bit set with pending data, or a command.
         // A write landing this cycle is caught next cycle through its flag.
         assign load[g] = (dirty_q[g] && (strobe_low || mask_q[g]))
                          || (do_upd && sel[g]) || do_upd_all;
         assign pwr_up[g] = do_pwr && dsel[g] && (new_pwr == QDAC_PWR_NORMAL)
                            && (pwr_q[g] != QDAC_PWR_NORMAL);
         // The stop level is held for as long as the channel sits in power-down, so the output
         // stays invalid the whole time and not only in the cycle of the command.
         assign pwr_dn[g] = (do_pwr && dsel[g] && (new_pwr != QDAC_PWR_NORMAL)) || do_full_rst
                            || ((pwr_q[g] != QDAC_PWR_NORMAL) && !pwr_up[g]);

         // Input register takes the received code.
         always_ff @(posedge clk_i) begin
            if (rst_i || do_rst) begin
               in_q[g] <= QDAC_CODE_RST;
            end else if (wr_now[g]) begin
               in_q[g] <= data;
            end
         end

         // Changed flag: a new write wins over the clear from a load.
         always_ff @(posedge clk_i) begin
            if (rst_i || do_rst) begin
               dirty_q[g] <= 1'b0;
            end else if (wr_now[g]) begin
               dirty_q[g] <= 1'b1;
            end else if (load[g]) begin
               dirty_q[g] <= 1'b0;
            end
         end

         // Converter register holds unless loaded; power changes leave it alone.
         always_ff @(posedge clk_i) begin
            if (rst_i || do_rst) begin
               conv_q[g] <= QDAC_CODE_RST;
            end else if (load[g]) begin
               conv_q[g] <= wr_now[g] ? data : in_q[g];
            end else begin
               conv_q[g] <= conv_q[g];
            end
         end

         // Power state: only selected channels change.
         always_ff @(posedge clk_i) begin
            if (rst_i || do_full_rst) begin
               pwr_q[g] <= QDAC_PWR_NORMAL;
            end else if (do_pwr && dsel[g]) begin
               pwr_q[g] <= new_pwr;
            end
         end

         // Recovery timer per channel.
         qdac_wake_timer #(
            .WAKE_CYC(WAKE_CYC)
         ) u_wake (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .start_i(pwr_up[g]),
            .stop_i(pwr_dn[g]),
            .ready_o(out_valid_o[g])
         );

         // Registered outputs.
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               conv_code_o[g*QDAC_CODE_W +: QDAC_CODE_W] <= QDAC_CODE_RST;
               pwr_state_o[g*2 +: 2] <= QDAC_PWR_NORMAL;
            end else begin
               conv_code_o[g*QDAC_CODE_W +: QDAC_CODE_W] <= conv_q[g];
               pwr_state_o[g*2 +: 2] <= pwr_q[g];
            end
         end
      end
   endgenerate

   // Mask mirror output.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         load_mask_o <= QDAC_MASK_RST;
      end else begin
         load_mask_o <= mask_q;
      end
   end
endmodule

// *** logic/qdac_pkg.sv ***
package qdac_pkg;
   // Frame field positions within the 24-bit write word.
   localparam int QDAC_FRAME_W = 24;
   localparam int QDAC_RSVD_BIT = 23;
   localparam int QDAC_BSEL_BIT = 22;
   localparam int QDAC_CMD_MSB = 21;
   localparam int QDAC_CMD_LSB = 19;
   localparam int QDAC_ADDR_MSB = 18;
   localparam int QDAC_ADDR_LSB = 16;
   localparam int QDAC_DATA_MSB = 15;
   localparam int QDAC_DATA_LSB = 0;
   localparam int QDAC_PSTATE_MSB = 5;
   localparam int QDAC_PSTATE_LSB = 4;
   localparam int QDAC_SEL_MSB = 3;
   localparam int QDAC_SEL_LSB = 0;
   localparam int QDAC_RST_BIT = 0;
   localparam int QDAC_NCHAN = 4;
   localparam int QDAC_CODE_W = 16;

   // Channel address codes.
   localparam logic [2:0] QDAC_ADDR_A = 3'h0;
   localparam logic [2:0] QDAC_ADDR_B = 3'h1;
   localparam logic [2:0] QDAC_ADDR_C = 3'h2;
   localparam logic [2:0] QDAC_ADDR_D = 3'h3;
   localparam logic [2:0] QDAC_ADDR_ALL = 3'h7;

   // Command codes.
   localparam logic [2:0] QDAC_CMD_WRITE = 3'h0;
   localparam logic [2:0] QDAC_CMD_UPDATE = 3'h1;
   localparam logic [2:0] QDAC_CMD_WRITE_UPD_ALL = 3'h2;
   localparam logic [2:0] QDAC_CMD_WRITE_UPD = 3'h3;
   localparam logic [2:0] QDAC_CMD_POWER = 3'h4;
   localparam logic [2:0] QDAC_CMD_RESET = 3'h5;
   localparam logic [2:0] QDAC_CMD_MASK = 3'h6;
   localparam logic [2:0] QDAC_CMD_REF = 3'h7;

   // Power states of one output.
   typedef enum logic [1:0] {
      QDAC_PWR_NORMAL = 2'h0,
      QDAC_PWR_PD_SMALL_R = 2'h1,
      QDAC_PWR_PD_LARGE_R = 2'h2,
      QDAC_PWR_PD_HIZ = 2'h3
   } qdac_pwr_t;

   // Reset values.
   localparam logic [3:0] QDAC_MASK_RST = 4'h0;
   localparam logic [15:0] QDAC_CODE_RST = 16'h0000;

   // Power-up recovery time and its cycle count at 40 MHz.
   localparam int QDAC_CLK_HZ = 40_000_000;
   localparam int QDAC_WAKE_US = 4;
   localparam int QDAC_WAKE_CYC = (QDAC_WAKE_US * (QDAC_CLK_HZ / 1_000_000) < 1) ? 1 :
                                  QDAC_WAKE_US * (QDAC_CLK_HZ / 1_000_000);
   localparam int QDAC_WAKE_CW = 8;

   // A received frame with its strobe.
   typedef struct packed {
      logic valid;
      logic [QDAC_FRAME_W-1:0] word;
   } qdac_frame_t;

   // Per-channel visible state.
   typedef struct packed {
      logic [QDAC_CODE_W-1:0] code;
      qdac_pwr_t pwr;
      logic ready;
   } qdac_chan_t;
endpackage

// *** logic/qdac_wake_timer.sv ***
`timescale 1ns/1ps
// Counts the recovery interval after a channel is powered up.
module qdac_wake_timer
   import qdac_pkg::*;
#(
   parameter int WAKE_CYC = QDAC_WAKE_CYC
) (
   input wire logic clk_i, // Clock.
   input wire logic rst_i, // Synchronous reset.
   input wire logic start_i, // Power-up command for this channel.
   input wire logic stop_i, // Channel powered down again.
   output logic ready_o // Output valid.
);
   // Refuse recovery counts that the counter below cannot hold.
   if (WAKE_CYC < 1 || WAKE_CYC >= (1 << QDAC_WAKE_CW)) begin : g_bad_wake
      $error("wake count out of range");
   end

   logic [QDAC_WAKE_CW-1:0] cnt_q; // Remaining recovery cycles.

   // A new power-up restarts the count; power-down clears it.
   always_ff @(posedge clk_i) begin
      if (rst_i || stop_i) begin
         cnt_q <= '0;
      end else if (start_i) begin
         cnt_q <= QDAC_WAKE_CW'(WAKE_CYC);
      end else if (cnt_q != '0) begin
         cnt_q <= cnt_q - 1'b1;
      end
   end

   // Ready only once the count has run out.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ready_o <= 1'b1;
      end else begin
         ready_o <= !stop_i && !start_i && (cnt_q <= 1);
      end
   end
endmodule

// *** test/qdac_assertions.sv ***
`timescale 1ns/1ps
// Port-level checks of the update and power control.
module qdac_chk
   import qdac_pkg::*;
#(
   parameter int WAKE_CYC = QDAC_WAKE_CYC
) (
   input wire logic clk_i, // Clock.
   input wire logic rst_i, // Reset.
   input wire qdac_frame_t frame_i, // Frame.
   input wire logic load_strobe_n_i, // Strobe pin.
   input wire logic [63:0] conv_code_o, // Codes.
   input wire logic [7:0] pwr_state_o, // Power.
   input wire logic [3:0] out_valid_o, // Valid.
   input wire logic [3:0] load_mask_o, // Mask.
   input wire logic ref_on_o // Reference.
);
   localparam int WMAX = WAKE_CYC + 6;
   logic v; // Frame strobe.
   logic [2:0] c; // Command.
   logic [2:0] a; // Address.
   logic [15:0] d; // Data.
   // The split keeps the properties short.
   assign v = frame_i.valid;
   assign c = frame_i.word[21:19];
   assign a = frame_i.word[18:16];
   assign d = frame_i.word[15:0];
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // Two quiet cycles, so no later frame blurs the result.
   sequence s_gap2;
      !v ##1 !v;
   endsequence
   AST_RST: assert property (disable iff (1'b0) rst_i ##1 rst_i |=> load_mask_o == 4'h0)
      else $error("mask not cleared by reset");
   AST_MASK: assert property (v && c == QDAC_CMD_MASK ##1 s_gap2 |-> load_mask_o == $past(d[3:0], 2))
      else $error("mask not loaded");
   AST_PWR: assert property (v && c == QDAC_CMD_POWER ##1 s_gap2 |-> pwr_state_o[1:0] ==
      ($past(d[0], 2) ? $past(d[5:4], 2) : $past(pwr_state_o[1:0], 1)))
      else $error("power state of A wrong");
   AST_PDINV: assert property (pwr_state_o[1:0] != 2'h0 && $past(pwr_state_o[1:0]) != 2'h0
      |-> !out_valid_o[0])
      else $error("powered-down output valid");
   AST_WAKE: assert property ($past(pwr_state_o[1:0]) != 2'h0 && pwr_state_o[1:0] == 2'h0
      |-> !out_valid_o[0] ##[1:WMAX] out_valid_o[0])
      else $error("recovery time wrong");
   AST_HOLD: assert property ((load_strobe_n_i && !v && load_mask_o == 4'h0)[*6] |=> $stable(conv_code_o))
      else $error("codes moved with strobe high");
   AST_ASYNC: assert property ((load_strobe_n_i && !v)[*2] ##1
      v && c == QDAC_CMD_WRITE && a == QDAC_ADDR_A && !load_mask_o[0] && load_strobe_n_i
      ##1 (!v && load_strobe_n_i)[*3] |-> conv_code_o[15:0] == $past(conv_code_o[15:0], 3))
      else $error("write reached output early");
   AST_SYNC: assert property (!v ##1 v && c == QDAC_CMD_WRITE && a == QDAC_ADDR_A && load_mask_o[0]
      ##1 s_gap2 |=> conv_code_o[15:0] == $past(d, 3))
      else $error("masked channel not updated");
   AST_WUPD: assert property (v && c == QDAC_CMD_WRITE_UPD && a == QDAC_ADDR_A
      ##1 !v |=> conv_code_o[15:0] == $past(d, 2))
      else $error("write and update failed");
endmodule

bind qdac_ctrl qdac_chk #(.WAKE_CYC(WAKE_CYC)) chk_u (.clk_i(clk_i), .rst_i(rst_i), .frame_i(frame_i),
   .load_strobe_n_i(load_strobe_n_i), .conv_code_o(conv_code_o), .pwr_state_o(pwr_state_o),
   .out_valid_o(out_valid_o), .load_mask_o(load_mask_o), .ref_on_o(ref_on_o));

// *** test/qdac_frame_src.sv ***
`timescale 1ns/1ps
// Bus controller stand-in: hands over one whole 24-bit frame per call.
module qdac_frame_src
   import qdac_pkg::*;
(
   output qdac_frame_t frame_o, // Frame with strobe.
   input wire logic clk_i // Clock.
);
   initial frame_o = '0;
   // Valid for one cycle, driven on the falling edge.
   task automatic send(input logic [23:0] w);
      @(negedge clk_i);
      frame_o.word = w;
      frame_o.valid = 1'b1;
      @(negedge clk_i);
      frame_o.valid = 1'b0;
      // Stale data must not look like a repeat frame.
      frame_o.word = ~w;
   endtask
endmodule

// *** test/tb_top.sv ***
`timescale 1ns/1ps
// Self-checking bench for the update and power control.
module tb_top import qdac_pkg::*;;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic strobe_n = 1'b1; // Load strobe pin.
   qdac_frame_t frame;
   logic [63:0] conv;
   logic [7:0] pwr;
   logic [3:0] ov;
   logic [3:0] mask;
   logic ref_on;
   logic [63:0] ec = '0; // Expected codes.
   logic [7:0] ep = '0; // Expected power.
   logic [3:0] ev = 4'hF; // Expected valid.
   logic [3:0] em = '0; // Expected mask.
   logic er = 1'b0; // Expected reference.
   int error_cnt = 0;
   int comparisons = 0;
   initial forever #12.5 clk_i = ~clk_i;
   qdac_frame_src src_u (.frame_o(frame), .clk_i(clk_i));
   qdac_ctrl #(.WAKE_CYC(4)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .frame_i(frame), .load_strobe_n_i(strobe_n),
      .conv_code_o(conv), .pwr_state_o(pwr), .out_valid_o(ov), .load_mask_o(mask), .ref_on_o(ref_on));
   // Whole visible state against the model.
   task automatic chk(input string n);
      comparisons++;
      if ({conv, pwr, ov, mask, ref_on} !== {ec, ep, ev, em, er}) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", n, {ec, ep, ev, em, er}, {conv, pwr, ov, mask, ref_on});
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge clk_i);
   endtask
   // Frame then settle; the gap outlasts every pipeline.
   task automatic put(input logic [2:0] c, input logic [2:0] a, input logic [15:0] d);
      src_u.send({2'b00, c, a, d});
      tick(6);
   endtask
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // Strobe high holds outputs; low on the last write updates all.
   task automatic t_async;
      put(QDAC_CMD_WRITE, QDAC_ADDR_A, 16'h1111);
      put(QDAC_CMD_WRITE, QDAC_ADDR_B, 16'h2222);
      chk("held");
      strobe_n = 1'b0;
      put(QDAC_CMD_WRITE, QDAC_ADDR_C, 16'h3333);
      ec = 64'h0000_3333_2222_1111;
      chk("joint");
      strobe_n = 1'b1;
      put(QDAC_CMD_WRITE, QDAC_ADDR_B, 16'h4444);
      put(QDAC_CMD_WRITE, 3'h4, 16'hDEAD);
      strobe_n = 1'b0;
      tick(6);
      ec[31:16] = 16'h4444;
      chk("changed only");
      $display("async done");
   endtask
   // Strobe low follows each word; then the update commands.
   task automatic t_sync;
      put(QDAC_CMD_WRITE, QDAC_ADDR_D, 16'h5555);
      ec[63:48] = 16'h5555;
      chk("sync");
      strobe_n = 1'b1;
      for (int i = 0; i < 4; i++) begin
         put(QDAC_CMD_WRITE_UPD, 3'(i), 16'h1000 + 16'(i));
         ec[i*16+:16] = 16'h1000 + 16'(i);
      end
      put(QDAC_CMD_WRITE_UPD, QDAC_ADDR_ALL, 16'hA5A5);
      ec = {4{16'hA5A5}};
      chk("write upd");
      put(QDAC_CMD_WRITE, QDAC_ADDR_B, 16'h0B0B);
      put(QDAC_CMD_UPDATE, QDAC_ADDR_B, 16'h0000);
      put(QDAC_CMD_WRITE, QDAC_ADDR_C, 16'h0C0C);
      put(QDAC_CMD_WRITE_UPD_ALL, QDAC_ADDR_A, 16'h0A0A);
      ec = 64'hA5A5_0C0C_0B0B_0A0A;
      chk("updates");
      $display("sync done");
   endtask
   // Mask bits bypass the pin for A and C.
   task automatic t_mask;
      put(QDAC_CMD_MASK, QDAC_ADDR_D, 16'hFFF5);
      em = 4'h5;
      put(QDAC_CMD_WRITE, QDAC_ADDR_ALL, 16'hBEEF);
      ec = 64'hA5A5_BEEF_0B0B_BEEF;
      chk("masked");
      strobe_n = 1'b0;
      tick(6);
      ec = {4{16'hBEEF}};
      chk("pin rest");
      strobe_n = 1'b1;
      // A lone write to a masked channel must reach the output with the pin high.
      put(QDAC_CMD_WRITE, QDAC_ADDR_A, 16'h0A11);
      ec[15:0] = 16'h0A11;
      chk("masked alone");
      $display("mask done");
   endtask
   // Every power state on A and B; codes stay put.
   task automatic t_power;
      for (int s = 3; s >= 0; s--) begin
         src_u.send({2'b00, QDAC_CMD_POWER, QDAC_ADDR_C, 10'h0, 2'(s), 4'h3});
         tick(2);
         ep[3:0] = {2'(s), 2'(s)};
         ev = 4'hC;
         chk("power");
         tick(8);
         ev = (s == 0) ? 4'hF : 4'hC;
         chk("recovered");
      end
      $display("power done");
   endtask
   // Partial reset keeps mask, power and reference; full clears them.
   task automatic t_swreset;
      put(QDAC_CMD_REF, QDAC_ADDR_A, 16'h0001);
      put(QDAC_CMD_POWER, QDAC_ADDR_A, 16'h0028);
      er = 1'b1;
      ep[7:6] = 2'h2;
      ev = 4'h7;
      put(QDAC_CMD_RESET, QDAC_ADDR_A, 16'h0000);
      ec = '0;
      chk("partial");
      put(QDAC_CMD_RESET, QDAC_ADDR_A, 16'h0001);
      {ep, ev, em, er} = {8'h00, 4'hF, 4'h0, 1'b0};
      chk("full");
      $display("reset done");
   endtask
   // Cut off a hang; the tests need only a few hundred cycles.
   initial begin
      repeat (5000) @(posedge clk_i);
      error_cnt++;
      report_and_stop;
   end
   initial begin
      repeat (3) @(posedge clk_i);
      @(negedge clk_i);
      rst_i = 1'b0;
      chk("reset");
      t_async;
      t_sync;
      t_mask;
      t_power;
      t_swreset;
      report_and_stop;
   end
endmodule
